// ---- mst_pkg.sv ----
// Constants, types and helpers shared by the Manchester transceiver
package mst_pkg;
  localparam int OSC_KHZ = 62208;
  localparam int CORE_KHZ = 200000;
  localparam int ACC_W = 18;
  localparam logic [ACC_W:0] OSC_STEP = 19'(OSC_KHZ);
  localparam logic [ACC_W:0] CORE_STEP = 19'(CORE_KHZ);
  localparam int W = 32;
  localparam int HW = 16;
  localparam int FIFO_DEPTH = 131072;
  localparam int LVL_W = 18;
  localparam logic [2:0] RATE_DEFAULT = 3'h2;
  localparam int RX_DIV_MIN = 5;
  localparam int RX_DIV_MAX = 12;
  localparam int RX_BIT_MIN = (RX_DIV_MIN * CORE_KHZ) / OSC_KHZ;
  localparam int RX_BIT_MAX = (RX_DIV_MAX * CORE_KHZ + OSC_KHZ - 1) / OSC_KHZ;
  localparam logic [6:0] RX_PER_RST = 7'(RX_BIT_MAX);
  localparam logic [7:0] FILLER = 8'h53;
  localparam logic [16:0] GAP_MIN = 17'h00480;
  localparam logic [16:0] GAP_MAX = 17'h10000;
  localparam int IRQ_W = 11;
  localparam int IRQ_TX_DONE = 0;
  localparam int IRQ_TX_AE = 1;
  localparam int IRQ_RX_AF = 2;
  localparam int IRQ_LOCK_GAIN = 3;
  localparam int IRQ_LOCK_LOSS = 4;
  localparam int IRQ_SYNC_WORD = 5;
  localparam int IRQ_INCOH = 6;
  localparam int IRQ_UART = 7;
  typedef enum logic [2:0] {H_IDLE = 3'h1, H_WAIT = 3'h2, H_TERM = 3'h4} host_st_t;
  typedef enum logic [2:0] {T_OFF = 3'h1, T_IDLE = 3'h2, T_SEND = 3'h4} tx_st_t;

  function automatic logic [2:0] rate_n(input logic [2:0] field);
    return (field == 3'h0) ? RATE_DEFAULT : field;
  endfunction : rate_n

  // Selected bytes moved to the top of the shifter, with the bit count below
  function automatic logic [W+5:0] tx_align(input logic [W-1:0] word, input logic [1:0] bytes);
    logic [W+5:0] r;
    case (bytes)
      2'h1: r = {word[7:0], 24'h000000, 6'h08};
      2'h2: r = {word[15:0], 16'h0000, 6'h10};
      2'h3: r = {word[23:0], 8'h00, 6'h18};
      default: r = {word, 6'h20};
    endcase
    return r;
  endfunction : tx_align
endpackage : mst_pkg

// ---- word_if.sv ----
// Valid/ready word channel between the transceiver's own modules
`timescale 1ns/10ps
interface word_if #(parameter int W = 32);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : word_if

// ---- word_fifo.sv ----
// Synchronous FIFO with a prefetched output register
`timescale 1ns/10ps
module word_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Channels
  word_if.snk wr,
  word_if.src rd,
  // Words held, output register included
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [W-1:0] od;
  } fifo_state_t;
  fifo_state_t s_q, s_d;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign wr.ready = (s_q.cnt != (AW + 1)'(DEPTH));
  assign push = wr.valid && wr.ready;
  // Refill the output word as soon as it is free or being taken
  assign pop = (s_q.cnt != '0) && (!s_q.ov || rd.ready);
  assign rd.valid = s_q.ov;
  assign rd.data = s_q.od;
  assign level = s_q.cnt + {{AW{1'b0}}, s_q.ov};

  always_comb begin
    s_d = s_q;
    if (push) s_d.wp = s_q.wp + 1'b1;
    if (rd.ready) s_d.ov = 1'b0;
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
      s_d.ov = 1'b1;
      s_d.od = mem[s_q.rp];
    end
    s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk) begin
    if (push) mem[s_q.wp] <= wr.data;
  end

  always_ff @(posedge clk) begin
    if (rst) s_q <= '0;
    else s_q <= s_d;
  end
endmodule : word_fifo

// ---- rx_decoder.sv ----
// Manchester decoder for one receive stream, 16-bit words out
`timescale 1ns/10ps
module rx_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control and line
  input wire logic enable,
  input wire logic line,
  // Decoded words and status
  output logic word_valid,
  output logic [mst_pkg::HW-1:0] word,
  output logic locked,
  output logic incoherent
);
  import mst_pkg::*;
  typedef struct packed {
    logic [2:0] sy;
    logic lvl;
    logic [6:0] cnt;
    logic [6:0] prev;
    logic [6:0] per;
    logic lock;
    logic [HW-1:0] sh;
    logic [3:0] nb;
    logic wv;
    logic [HW-1:0] wd;
    logic inc;
  } dec_state_t;
  dec_state_t s_q, s_d;
  logic edge_seen;

  always_comb begin
    s_d = s_q;
    s_d.wv = 1'b0;
    s_d.inc = 1'b0;
    s_d.sy = {s_q.sy[1:0], line};
    edge_seen = (s_q.sy[1] == s_q.sy[2]) && (s_q.sy[2] != s_q.lvl);
    if (s_q.cnt != 7'h7F) s_d.cnt = s_q.cnt + 7'h01;
    if (edge_seen) begin
      s_d.lvl = s_q.sy[2];
      if (!s_q.lock) begin
        // A long gap after a short one can only span two mid-bit edges
        s_d.prev = s_q.cnt;
        s_d.cnt = 7'h00;
        if (enable && s_q.prev != 7'h00 && int'(s_q.cnt) * 2 >= int'(s_q.prev) * 3
            && int'(s_q.cnt) >= RX_BIT_MIN && int'(s_q.cnt) <= RX_BIT_MAX) begin
          s_d.lock = 1'b1;
          s_d.per = s_q.cnt;
          s_d.nb = 4'h0;
        end
      end else if (int'(s_q.cnt) * 4 > int'(s_q.per) * 3) begin
        s_d.cnt = 7'h00;
        s_d.per = s_q.cnt;
        s_d.sh = {s_q.sh[HW-2:0], s_q.lvl};
        s_d.nb = s_q.nb + 4'h1;
        if (s_q.nb == 4'hF) begin
          s_d.wv = 1'b1;
          s_d.wd = {s_q.sh[HW-2:0], s_q.lvl};
        end
      end
    end
    // Missing mid-bit edge: the bit clock no longer matches
    if (s_q.lock && int'(s_q.cnt) * 2 > int'(s_q.per) * 3) begin
      s_d.inc = 1'b1;
      s_d.lock = 1'b0;
      s_d.prev = 7'h00;
    end
    if (!enable) s_d.lock = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.per <= RX_PER_RST;
      // Undriven line idles high; starting there avoids a false edge after reset
      s_q.sy <= 3'h7;
      s_q.lvl <= 1'h1;
    end else begin
      s_q <= s_d;
    end
  end

  assign word_valid = s_q.wv;
  assign word = s_q.wd;
  assign locked = s_q.lock;
  assign incoherent = s_q.inc;
endmodule : rx_decoder

// ---- manchester_serial_transceiver.sv ----
// Manchester serial transceiver: host target, FIFOs, encoder, paired receiver, interrupts
//
// Notes on behaviour
// - Transmit rate divides the 62.208 MHz oscillator.
// - Receiver follows rates from divide-5 to divide-12.
// - Both FIFOs run on the core clock.
// - Each channel has a 128K by 32 FIFO.
// - Host write latched, cycle ends after one wait state unless the latch is full.
// - Next FIFO word is prefetched for reads.
// - Two 16-bit stream halves form one word.
// - Send 32 bits or lowest 1-3 bytes, MSB first.
// - Empty FIFO sends 0x53 every programmed interval.
// - Idle bits repeat the two-bit idle pattern.
// - Queued data replaces 0x53 at next slot.
// - Interrupt when a data message is fully sent.
// - Sources: FIFO levels, lock, sync word, incoherence.
// - Per-source enables plus one master enable.
// - Four UART interrupt sources.
// - Exactly one wait state on every read; a write waits longer while the latch is full.
// - Every bit period carries a transition.
// - Bit value first half, inverse second half.
// - Further FIFO words follow without any gap.
// - Three-bit rate field, zero means divide-six.
// - Receiver locks on transitions, tells mid from boundary.
// - Rate is oscillator over twice n plus two.
// - Latched status clears by writing one.
// - Only the disable control stops transmission.
`timescale 1ns/10ps
module manchester_serial_transceiver (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Host target
  input wire logic HOST_REQ,
  input wire logic HOST_WR,
  input wire logic [mst_pkg::W-1:0] HOST_WDATA,
  output logic [mst_pkg::W-1:0] HOST_RDATA,
  output logic HOST_ACK,
  // Transmit control
  input wire logic TX_DISABLE,
  input wire logic [2:0] TX_RATE,
  input wire logic [1:0] TX_BYTES,
  input wire logic [1:0] TX_IDLE_PAT,
  input wire logic [16:0] TX_INTERVAL,
  input wire logic [mst_pkg::LVL_W-1:0] TX_AE_LEVEL,
  // Receive control
  input wire logic RX_ENABLE,
  input wire logic [mst_pkg::LVL_W-1:0] RX_AF_LEVEL,
  // Serial lines
  output logic TX_DATA,
  output logic TX_OE,
  input wire logic RX_DATA_A,
  input wire logic RX_DATA_B,
  // Sync detector and UART events
  input wire logic SYNC_LOCK,
  input wire logic SYNC_WORD_SEEN,
  input wire logic [3:0] UART_EVENTS,
  // Interrupts
  input wire logic [mst_pkg::IRQ_W-1:0] IRQ_ENABLE,
  input wire logic IRQ_MASTER_EN,
  input wire logic [mst_pkg::IRQ_W-1:0] IRQ_CLEAR,
  output logic [mst_pkg::IRQ_W-1:0] IRQ_STATUS,
  output logic IRQ_OUT,
  // Status
  output logic TX_FIFO_EMPTY,
  output logic TX_FIFO_FULL,
  output logic RX_FIFO_EMPTY,
  output logic RX_FIFO_FULL,
  output logic RX_LOCKED,
  output logic RX_OVERRUN
);
  import mst_pkg::*;

  typedef struct packed {
    host_st_t hs;
    logic hwr;
    logic [W-1:0] hwd;
    logic [W-1:0] rdata;
    logic hold_v;
    logic [W-1:0] hold_d;
    tx_st_t ts;
    logic [ACC_W-1:0] acc;
    logic [2:0] hcnt;
    logic half;
    logic bitv;
    logic line;
    logic oe;
    logic [W-1:0] sh;
    logic [5:0] nbits;
    logic [16:0] icnt;
    logic pat_ph;
    logic msg_data;
    logic [HW-1:0] pa;
    logic [HW-1:0] pb;
    logic pav;
    logic pbv;
    logic pv;
    logic [W-1:0] pd;
    logic ovr;
    logic [IRQ_W-1:0] irq;
    logic irq_out;
    logic ae_q;
    logic af_q;
    logic lock_q;
    logic [4:0] flags;
  } top_state_t;

  top_state_t s_q, s_d;

  word_if #(.W(W)) txw ();
  word_if #(.W(W)) txr ();
  word_if #(.W(W)) rxw ();
  word_if #(.W(W)) rxr ();

  logic [LVL_W-1:0] tx_lvl;
  logic [LVL_W-1:0] rx_lvl;
  logic va;
  logic vb;
  logic [HW-1:0] wa;
  logic [HW-1:0] wb;
  logic lock_a;
  logic lock_b;
  logic inc_a;
  logic inc_b;

  // Comb helpers
  logic [ACC_W:0] acc_sum;
  logic tick;
  logic half_end;
  logic bit_end;
  logic [2:0] n;
  logic [16:0] gap;
  logic slot_due;
  logic load_word;
  logic host_pop;
  logic tx_done;
  logic ae_now;
  logic af_now;
  logic [IRQ_W-1:0] ev;

  // Deep storage per channel, clocked by the single core clock
  word_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .wr(txw),
    .rd(txr),
    .level(tx_lvl)
  );

  word_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .wr(rxw),
    .rd(rxr),
    .level(rx_lvl)
  );

  rx_decoder dec_a (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .enable(RX_ENABLE),
    .line(RX_DATA_A),
    .word_valid(va),
    .word(wa),
    .locked(lock_a),
    .incoherent(inc_a)
  );

  rx_decoder dec_b (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .enable(RX_ENABLE),
    .line(RX_DATA_B),
    .word_valid(vb),
    .word(wb),
    .locked(lock_b),
    .incoherent(inc_b)
  );

  assign txw.valid = s_q.hold_v;
  assign txw.data = s_q.hold_d;
  assign txr.ready = load_word;
  assign rxw.valid = s_q.pv;
  assign rxw.data = s_q.pd;
  assign rxr.ready = host_pop;

  always_comb begin
    s_d = s_q;
    load_word = 1'b0;
    host_pop = 1'b0;

    // Host target: taken, one wait state, then terminate with data
    if (s_q.hold_v && txw.ready) s_d.hold_v = 1'b0;
    case (s_q.hs)
      H_IDLE: begin
        // A write waits only while the previous one still sits in the latch
        if (HOST_REQ && (!HOST_WR || !s_q.hold_v)) begin
          s_d.hs = H_WAIT;
          s_d.hwr = HOST_WR;
          s_d.hwd = HOST_WDATA;
        end
      end
      H_WAIT: begin
        s_d.hs = H_TERM;
        if (s_q.hwr) begin
          s_d.hold_v = 1'b1;
          s_d.hold_d = s_q.hwd;
        end else if (rxr.valid) begin
          s_d.rdata = rxr.data;
          host_pop = 1'b1;
        end else begin
          s_d.rdata = '0;
        end
      end
      H_TERM: begin
        s_d.hs = H_IDLE;
      end
      default: begin
        s_d.hs = H_IDLE;
      end
    endcase

    // Oscillator rate rebuilt from the core clock by a phase accumulator
    acc_sum = {1'b0, s_q.acc} + OSC_STEP;
    tick = (acc_sum >= CORE_STEP);
    s_d.acc = tick ? ACC_W'(acc_sum - CORE_STEP) : acc_sum[ACC_W-1:0];
    n = rate_n(TX_RATE);
    half_end = tick && (s_q.hcnt == n);
    bit_end = half_end && s_q.half;
    if (tick) s_d.hcnt = half_end ? 3'h0 : s_q.hcnt + 3'h1;
    if (half_end) s_d.half = ~s_q.half;

    gap = TX_INTERVAL;
    if (TX_INTERVAL < GAP_MIN) gap = GAP_MIN;
    if (TX_INTERVAL > GAP_MAX) gap = GAP_MAX;
    slot_due = ({1'b0, s_q.icnt} + 18'h00001) >= {1'b0, gap};
    tx_done = 1'b0;

    case (s_q.ts)
      T_OFF: begin
        s_d.hcnt = 3'h0;
        s_d.half = 1'b0;
        if (!TX_DISABLE) begin
          s_d.ts = T_IDLE;
          s_d.icnt = GAP_MAX;
          s_d.pat_ph = 1'b1;
          s_d.bitv = TX_IDLE_PAT[1];
        end
      end
      T_IDLE, T_SEND: begin
        if (TX_DISABLE) begin
          s_d.ts = T_OFF;
        end else if (bit_end) begin
          if (s_q.icnt != 17'h1FFFF) s_d.icnt = s_q.icnt + 17'h00001;
          if (s_q.ts == T_SEND && s_q.msg_data && s_q.nbits == 6'h01 && !txr.valid) tx_done = 1'b1;
          if (s_q.ts == T_SEND && s_q.nbits != 6'h01) begin
            s_d.sh = {s_q.sh[W-2:0], 1'b0};
            s_d.nbits = s_q.nbits - 6'h01;
            s_d.bitv = s_q.sh[W-2];
          end else if (s_q.ts == T_SEND && s_q.msg_data && txr.valid) begin
            load_word = 1'b1;
            {s_d.sh, s_d.nbits} = tx_align(txr.data, TX_BYTES);
            s_d.bitv = txr.data[W-1] & (TX_BYTES == 2'h0) | s_d.sh[W-1] & (TX_BYTES != 2'h0);
          end else if (slot_due) begin
            s_d.icnt = 17'h00000;
            s_d.ts = T_SEND;
            if (txr.valid) begin
              load_word = 1'b1;
              s_d.msg_data = 1'b1;
              {s_d.sh, s_d.nbits} = tx_align(txr.data, TX_BYTES);
            end else begin
              s_d.msg_data = 1'b0;
              s_d.sh = {FILLER, 24'h000000};
              s_d.nbits = 6'h08;
            end
            s_d.bitv = s_d.sh[W-1];
          end else begin
            s_d.ts = T_IDLE;
            s_d.msg_data = 1'b0;
            s_d.bitv = s_q.pat_ph ? TX_IDLE_PAT[0] : TX_IDLE_PAT[1];
            s_d.pat_ph = ~s_q.pat_ph;
          end
        end
      end
      default: begin
        s_d.ts = T_OFF;
      end
    endcase
    // Inverting for the second half guarantees a mid-bit edge
    s_d.line = (s_d.ts == T_OFF) ? 1'b0 : (s_d.half ? ~s_d.bitv : s_d.bitv);
    s_d.oe = (s_d.ts != T_OFF);

    // Receive pairing
    if (s_q.pv && rxw.ready) s_d.pv = 1'b0;
    if (s_q.pav && s_q.pbv) begin
      // No back-pressure on a serial line: a pair with no room is lost
      if (s_q.pv && !rxw.ready) begin
        s_d.ovr = 1'b1;
      end else begin
        s_d.pv = 1'b1;
        s_d.pd = {s_q.pa, s_q.pb};
      end
      s_d.pav = 1'b0;
      s_d.pbv = 1'b0;
    end
    if (va) begin
      s_d.pa = wa;
      s_d.pav = 1'b1;
    end
    if (vb) begin
      s_d.pb = wb;
      s_d.pbv = 1'b1;
    end
    if (!RX_ENABLE) begin
      s_d.pav = 1'b0;
      s_d.pbv = 1'b0;
    end

    // Interrupt sources: FIFO levels and lock latched on their edges, other events while high
    ae_now = (tx_lvl <= TX_AE_LEVEL);
    af_now = (rx_lvl >= RX_AF_LEVEL);
    s_d.ae_q = ae_now;
    s_d.af_q = af_now;
    s_d.lock_q = SYNC_LOCK;
    ev = '0;
    ev[IRQ_TX_DONE] = tx_done;
    ev[IRQ_TX_AE] = ae_now && !s_q.ae_q;
    ev[IRQ_RX_AF] = af_now && !s_q.af_q;
    ev[IRQ_LOCK_GAIN] = SYNC_LOCK && !s_q.lock_q;
    ev[IRQ_LOCK_LOSS] = !SYNC_LOCK && s_q.lock_q;
    ev[IRQ_SYNC_WORD] = SYNC_WORD_SEEN;
    ev[IRQ_INCOH] = inc_a || inc_b;
    ev[IRQ_UART +: 4] = UART_EVENTS;
    // A new event in the clearing cycle stays set
    s_d.irq = (s_q.irq & ~IRQ_CLEAR) | ev;
    s_d.irq_out = IRQ_MASTER_EN && |(s_d.irq & IRQ_ENABLE);

    s_d.flags = {tx_lvl == '0, !txw.ready, rx_lvl == '0, !rxw.ready, lock_a && lock_b};
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      s_q <= '0;
      s_q.hs <= H_IDLE;
      s_q.ts <= T_OFF;
      s_q.ae_q <= 1'b1;
      s_q.flags <= 5'h14;
    end else begin
      s_q <= s_d;
    end
  end

  assign HOST_RDATA = s_q.rdata;
  assign HOST_ACK = (s_q.hs == H_TERM);
  assign TX_DATA = s_q.line;
  assign TX_OE = s_q.oe;
  assign IRQ_STATUS = s_q.irq;
  assign IRQ_OUT = s_q.irq_out;
  assign TX_FIFO_EMPTY = s_q.flags[4];
  assign TX_FIFO_FULL = s_q.flags[3];
  assign RX_FIFO_EMPTY = s_q.flags[2];
  assign RX_FIFO_FULL = s_q.flags[1];
  assign RX_LOCKED = s_q.flags[0];
  assign RX_OVERRUN = s_q.ovr;
endmodule : manchester_serial_transceiver

// ---- mst_sva.sv ----
// Port-level assertions for the Manchester transceiver
`timescale 1ns/10ps
module mst_checker (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Host and transmitter
  input wire logic HOST_REQ,
  input wire logic HOST_WR,
  input wire logic HOST_ACK,
  input wire logic TX_DISABLE,
  input wire logic TX_DATA,
  input wire logic TX_OE,
  // Interrupts
  input wire logic SYNC_WORD_SEEN,
  input wire logic [3:0] UART_EVENTS,
  input wire logic [mst_pkg::IRQ_W-1:0] IRQ_ENABLE,
  input wire logic IRQ_MASTER_EN,
  input wire logic [mst_pkg::IRQ_W-1:0] IRQ_CLEAR,
  input wire logic [mst_pkg::IRQ_W-1:0] IRQ_STATUS,
  input wire logic IRQ_OUT
);
  import mst_pkg::*;
  // Slowest bit period is about 52 core cycles
  localparam int RUN_MAX = 53;
  logic [7:0] run_q;
  logic last_q;
  logic [3:0] uart_q;
  always_ff @(posedge CORE_CLK) begin
    last_q <= TX_DATA;
    uart_q <= SYS_RST ? 4'h0 : UART_EVENTS & IRQ_ENABLE[10:7];
    if (SYS_RST || !TX_OE || TX_DATA != last_q) begin
      run_q <= 8'h00;
    end else if (run_q != 8'hFF) begin
      run_q <= run_q + 8'h01;
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  AST_ACK_PULSE: assert property (HOST_ACK |=> !HOST_ACK)
    else $error("host ack wider than one cycle");
  AST_ACK_CAUSE: assert property (HOST_ACK |-> $past(HOST_REQ) && $past(HOST_REQ, 2))
    else $error("host ack without a held request");
  AST_READ_WAIT: assert property ($rose(HOST_REQ) && !HOST_WR |-> !HOST_ACK ##1 !HOST_ACK ##1 HOST_ACK)
    else $error("read not answered after one wait state");
  AST_TX_STOP: assert property (TX_DISABLE |=> !TX_OE && !TX_DATA)
    else $error("transmitter running while disabled");
  AST_TX_KEEP: assert property (TX_OE && !TX_DISABLE |=> TX_OE)
    else $error("transmitter stopped without disable");
  AST_TX_START: assert property ($fell(TX_DISABLE) |=> TX_OE)
    else $error("transmitter did not start");
  AST_TRANSITION: assert property (TX_OE |-> run_q < RUN_MAX)
    else $error("bit period without transition");
  AST_IRQ_MASTER: assert property (!IRQ_MASTER_EN [*2] |-> !IRQ_OUT)
    else $error("interrupt despite master disable");
  AST_IRQ_NONE: assert property (((IRQ_STATUS & IRQ_ENABLE) == '0) [*2] |-> !IRQ_OUT)
    else $error("interrupt with no enabled source");
  AST_IRQ_RAISE: assert property ((IRQ_MASTER_EN && (IRQ_STATUS & IRQ_ENABLE) != '0) [*2] |-> IRQ_OUT)
    else $error("enabled source not signalled");
  AST_STICKY: assert property ((~IRQ_STATUS & $past(IRQ_STATUS) & ~$past(IRQ_CLEAR)) == '0)
    else $error("status bit fell without clear");
  AST_UART_SET: assert property (uart_q != 4'h0 |-> (IRQ_STATUS[10:7] & uart_q) == uart_q)
    else $error("uart event not latched");
  AST_SYNC_SET: assert property (SYNC_WORD_SEEN && IRQ_ENABLE[IRQ_SYNC_WORD] |=> IRQ_STATUS[IRQ_SYNC_WORD])
    else $error("sync word event not latched");
endmodule : mst_checker

bind manchester_serial_transceiver mst_checker u_mst_checker (.*);

// ---- mst_remote.sv ----
// Remote serial equipment: paired Manchester sender and line sampler
`timescale 1ns/10ps
module mst_remote #(
  parameter real HALF_CYC = 9.645
) (
  // Clock
  input wire logic CORE_CLK,
  // Lines
  input wire logic TX_DATA,
  input wire logic TX_OE,
  output logic RX_DATA_A,
  output logic RX_DATA_B
);
  logic tx_half [0:4699];
  int n_half = 0;
  int cyc = 0;
  initial begin
    RX_DATA_A = 1'h1;
    RX_DATA_B = 1'h1;
  end
  // Mid half-bit sampling keeps clear of accumulator jitter
  always @(posedge CORE_CLK) begin
    if (!TX_OE) begin
      cyc = 0;
      n_half = 0;
    end else begin
      if (n_half < 4700 && cyc == $rtoi((n_half + 0.5) * HALF_CYC)) begin
        tx_half[n_half] = TX_DATA;
        n_half++;
      end
      cyc++;
    end
  end
  // Ones preamble, then alternating bits; B is A inverted until both lines are released
  task automatic send_pair(input realtime half, input int reps);
    logic b;
    for (int k = -8; k < reps * 16; k++) begin
      b = (k < 0) ? 1'h1 : ~k[0];
      RX_DATA_A = b;
      RX_DATA_B = ~b;
      #(half);
      RX_DATA_A = ~b;
      RX_DATA_B = b;
      #(half);
    end
    // Released lines float to the pull-up level
    RX_DATA_A = 1'h1;
    RX_DATA_B = 1'h1;
  endtask : send_pair
endmodule : mst_remote

// ---- manchester_serial_transceiver_tb.sv ----
// Self-checking bench for the Manchester transceiver
`timescale 1ns/10ps
module manchester_serial_transceiver_tb;
  import mst_pkg::*;
  localparam logic [W-1:0] WORD_A = 32'h12F0A5C3;
  localparam logic [W-1:0] WORD_B = 32'h340F5A3C;
  localparam int S2 = 1 + 1152;
  localparam int S3 = 1 + 2 * 1152;
  logic CORE_CLK, SYS_RST, HOST_REQ, HOST_WR, HOST_ACK, TX_DISABLE, RX_ENABLE;
  logic TX_DATA, TX_OE, RX_DATA_A, RX_DATA_B, SYNC_LOCK, SYNC_WORD_SEEN, IRQ_MASTER_EN, IRQ_OUT;
  logic TX_FIFO_EMPTY, TX_FIFO_FULL, RX_FIFO_EMPTY, RX_FIFO_FULL, RX_LOCKED, RX_OVERRUN;
  logic [W-1:0] HOST_WDATA, HOST_RDATA;
  logic [2:0] TX_RATE;
  logic [1:0] TX_BYTES, TX_IDLE_PAT;
  logic [16:0] TX_INTERVAL;
  logic [LVL_W-1:0] TX_AE_LEVEL, RX_AF_LEVEL;
  logic [3:0] UART_EVENTS;
  logic [IRQ_W-1:0] IRQ_ENABLE, IRQ_CLEAR, IRQ_STATUS;
  int err_total = 0;
  int n_checks = 0;

  manchester_serial_transceiver u_manchester_serial_transceiver (.*);
  // Field zero means n = 2, so a half bit is three oscillator ticks
  mst_remote #(.HALF_CYC(3.0 * CORE_KHZ / OSC_KHZ)) u_mst_remote (.*);

  initial begin
    CORE_CLK = 1'h0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end

  function automatic logic note(input logic bad);
    n_checks++;
    return bad;
  endfunction : note

  task automatic fail(input string m);
    err_total++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : fail

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task automatic host_xfer(input logic wr, input logic [W-1:0] wd, output logic [W-1:0] rd);
    int i;
    @(posedge CORE_CLK);
    HOST_REQ <= 1'h1;
    HOST_WR <= wr;
    HOST_WDATA <= wd;
    for (i = 0; i < 40; i++) begin
      @(posedge CORE_CLK);
      if (HOST_ACK === 1'h1) break;
    end
    rd = HOST_RDATA;
    HOST_REQ <= 1'h0;
    if (note(i != 2)) fail("ack not after one wait state");
    if (i == 40) finish_test();
  endtask : host_xfer

  initial begin
    logic [W-1:0] rd;
    logic b;
    int i, bi, got, inv_bad, dat_bad, idl_bad;
    realtime half;
    {HOST_REQ, HOST_WR, HOST_WDATA, RX_ENABLE, SYNC_LOCK, SYNC_WORD_SEEN, UART_EVENTS, IRQ_CLEAR, TX_RATE} = '0;
    {IRQ_MASTER_EN, TX_AE_LEVEL, RX_AF_LEVEL} = {1'h0, 18'h00001, 18'h00004};
    SYS_RST = 1'h1;
    TX_DISABLE = 1'h1;
    TX_BYTES = 2'h3;
    TX_IDLE_PAT = 2'h2;
    TX_INTERVAL = GAP_MIN;
    IRQ_ENABLE = 11'h7B8;
    repeat (3) @(posedge CORE_CLK);
    SYS_RST <= 1'h0;
    host_xfer(1'h0, '0, rd);
    if (note(rd !== 32'h0)) fail("read of empty fifo not zero");
    for (int e = 0; e < 7; e++) begin
      bi = (e < 4) ? 7 + e : e - 1;
      @(posedge CORE_CLK);
      IRQ_MASTER_EN <= e[0];
      UART_EVENTS <= (e < 4) ? 4'h1 << e : 4'h0;
      SYNC_LOCK <= (e == 4);
      SYNC_WORD_SEEN <= (e == 6);
      @(posedge CORE_CLK);
      UART_EVENTS <= 4'h0;
      SYNC_WORD_SEEN <= 1'h0;
      repeat (3) @(posedge CORE_CLK);
      if (note(IRQ_STATUS[bi] !== 1'h1)) fail("source not latched");
      if (note(IRQ_OUT !== e[0])) fail("master enable not obeyed");
      IRQ_CLEAR <= IRQ_W'(1) << bi;
      @(posedge CORE_CLK);
      IRQ_CLEAR <= '0;
      repeat (2) @(posedge CORE_CLK);
      if (note(IRQ_STATUS[bi] !== 1'h0)) fail("status not cleared");
    end
    TX_DISABLE <= 1'h0;
    for (i = 0; i < 2000 && u_mst_remote.n_half < 40; i++) @(posedge CORE_CLK);
    if (note(i == 2000)) fail("transmitter silent");
    if (note(IRQ_STATUS[IRQ_TX_DONE] !== 1'h0)) fail("done raised by filler");
    host_xfer(1'h1, WORD_A, rd);
    host_xfer(1'h1, WORD_B, rd);
    repeat (6) @(posedge CORE_CLK);
    if (note(TX_FIFO_EMPTY !== 1'h0)) fail("words not held for slot");
    for (int r = 0; r < 2; r++) begin
      @(posedge CORE_CLK);
      RX_ENABLE <= 1'h1;
      half = (r ? 10.0 : 6.0) * 1.0E6 / (2.0 * OSC_KHZ);
      u_mst_remote.send_pair(half, 6);
      repeat (20) @(posedge CORE_CLK);
      got = 0;
      for (int n = 0; n < 16; n++) begin
        repeat (4) @(posedge CORE_CLK);
        if (RX_FIFO_EMPTY !== 1'h0) break;
        host_xfer(1'h0, '0, rd);
        got++;
        if (note(rd !== 32'hAAAA5555 && rd !== 32'h5555AAAA)) fail("bad received pair");
      end
      if (note(got < 3 || got > 6)) fail("received word count");
      if (note(RX_LOCKED !== 1'h0 || IRQ_STATUS[IRQ_INCOH] !== 1'h1)) fail("no unlock on lost clock");
      RX_ENABLE <= 1'h0;
      repeat (4) @(posedge CORE_CLK);
    end
    if (note(RX_OVERRUN !== 1'h0 || RX_FIFO_FULL !== 1'h0)) fail("pair lost");
    for (i = 0; i < 60000 && u_mst_remote.n_half < 2 * (S3 + 8); i++) @(posedge CORE_CLK);
    if (note(i == 60000)) begin
      fail("transmit capture timed out");
      finish_test();
    end
    {inv_bad, dat_bad, idl_bad} = '0;
    for (int k = 0; k < S3 + 8; k++) begin
      b = u_mst_remote.tx_half[2 * k];
      if (u_mst_remote.tx_half[2 * k + 1] !== ~b) inv_bad++;
      if (k == 0 && b !== TX_IDLE_PAT[1]) dat_bad++;
      if (k >= 1 && k <= 8 && b !== FILLER[8 - k]) dat_bad++;
      if (k >= S2 && k < S2 + 24 && b !== WORD_A[S2 + 23 - k]) dat_bad++;
      if (k >= S2 + 24 && k < S2 + 48 && b !== WORD_B[S2 + 47 - k]) dat_bad++;
      if (k >= S3 && b !== FILLER[S3 + 7 - k]) dat_bad++;
      if (((k > 9 && k < S2) || (k > S2 + 48 && k < S3)) && b === u_mst_remote.tx_half[2 * k - 2]) idl_bad++;
    end
    if (note(inv_bad != 0)) fail("half bits not inverted");
    if (note(dat_bad != 0)) fail("slot contents wrong");
    if (note(idl_bad != 0)) fail("idle pattern wrong");
    if (note(TX_FIFO_EMPTY !== 1'h1 || TX_FIFO_FULL !== 1'h0)) fail("tx fifo not drained");
    if (note(IRQ_STATUS[IRQ_TX_DONE] !== 1'h1)) fail("no done after message");
    finish_test();
  end
endmodule : manchester_serial_transceiver_tb
